// File: hw/adcsc_params.svh
`ifndef ADCSC_PARAMS_SVH
`define ADCSC_PARAMS_SVH
// Register byte offsets
`define ADCSC_OFF_SC 12'h000
`define ADCSC_OFF_CFG 12'h004
`define ADCSC_OFF_RESL 12'h008
`define ADCSC_OFF_IRQ_STAT 12'h00c
`define ADCSC_OFF_IRQ_MASK 12'h010
// Status/control field positions
`define ADCSC_BIT_DONE 7
`define ADCSC_BIT_IRQ_EN 6
`define ADCSC_BIT_CONT 5
`define ADCSC_CH_MSB 4
// Config field positions
`define ADCSC_BIT_HWTRG 0
`define ADCSC_BIT_CMP_EN 1
// Reset values
`define ADCSC_SC_RESET 8'h1f
`define ADCSC_CFG_RESET 2'h0
// Channel codes
`define ADCSC_CH_LAST_EXT 5'h1b
`define ADCSC_CH_RSVD 5'h1c
`define ADCSC_CH_HIGH_REFERENCE 5'h1d
`define ADCSC_CH_LOW_REFERENCE 5'h1e
`define ADCSC_CH_OFF 5'h1f
// Number of analog inputs
`define ADCSC_N_INPUTS 28
// AXI responses
`define ADCSC_RESP_OKAY 2'h0
`define ADCSC_RESP_SLVERR 2'h2
`endif

// File: hw/adcsc_pkg.sv
package adcsc_pkg;
  // Selection presented to the analog multiplexer
  typedef struct packed {
    logic [27:0] input_onehot;
    logic high_reference;
    logic low_reference;
  } adcsc_mux_t;
  // Handshake with the analog converter core
  typedef struct packed {
    logic start;
    logic abort;
    logic powered;
  } adcsc_core_ctl_t;
  typedef struct packed {
    logic done;
    logic cmp_true;
    logic [7:0] result_low;
  } adcsc_core_sts_t;
  // Conversion sequencer states
  typedef enum logic [2:0] {
    ADCSC_IDLE = 3'b001,
    ADCSC_ARMED = 3'b010,
    ADCSC_BUSY = 3'b100
  } adcsc_state_t;
endpackage : adcsc_pkg

// File: hw/adcsc_chan_decode.sv
`timescale 1ns/1ps
`include "adcsc_params.svh"
// Channel field to multiplexer selection
module adcsc_chan_decode (
  input wire logic [4:0] input_channel_sel,
  output adcsc_pkg::adcsc_mux_t mux_sel
);
  import adcsc_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // Combinational decode, all-ones leaves every source open
  always_comb begin
    mux_sel = '0;
    if (input_channel_sel <= `ADCSC_CH_LAST_EXT) begin
      mux_sel.input_onehot = 28'(28'h1 << input_channel_sel);
    end else if (input_channel_sel == `ADCSC_CH_HIGH_REFERENCE) begin
      mux_sel.high_reference = 1'b1;
    end else if (input_channel_sel == `ADCSC_CH_LOW_REFERENCE) begin
      mux_sel.low_reference = 1'b1;
    end
    // Reserved and off codes select nothing
  end
endmodule : adcsc_chan_decode

// File: hw/adcsc_ctrl.sv
`timescale 1ns/1ps
`include "adcsc_params.svh"
// Notes on behaviour
// - No compare: every finished conversion sets flag
// - Compare on: flag set only if true
// - Control write or low result read clears
// - Flag set with enable high raises interrupt when the mask register bit is set
// - Single mode: one conversion per trigger
// - Continuous software mode starts on write
// - Continuous hardware mode starts on trigger
// - Five-bit field bits 4:0 picks input
// - Decode inputs 0-27, references, reserved code
// - All-ones code powers the converter off
// - All-ones code disconnects every input
// - All-ones stop write starts no conversion
// - Single mode idles low power after completion
// - Up to 28 selectable analog inputs
// - Compare enable works in every mode
// - Converter off in reset or all-ones
module adcsc_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic hw_conv_trigger,
  input wire adcsc_pkg::adcsc_core_sts_t core_sts,
  output adcsc_pkg::adcsc_core_ctl_t core_ctl,
  output adcsc_pkg::adcsc_mux_t mux_sel,
  output logic irq
);
  import adcsc_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] sc_reg; // Status/control register
  logic [1:0] cfg_reg; // Trigger select and compare enable
  logic [7:0] resl_reg; // Low result
  logic irq_stat_reg; // Sticky completion event
  logic irq_mask_reg; // Event mask
  logic aw_hold_reg, w_hold_reg; // Captured write halves
  logic [11:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic trg_s1_reg, trg_s2_reg, trg_s3_reg; // Trigger synchroniser and edge
  adcsc_state_t state_reg;
  adcsc_mux_t mux_next;
  logic wr_go, wr_sc, rd_go, rd_resl, trg_edge, chan_off, done_ok;
  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake terms
  assign wr_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  assign wr_sc = wr_go && aw_addr_reg == `ADCSC_OFF_SC && w_strb_reg[0];
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign rd_resl = rd_go && s_axi_araddr == `ADCSC_OFF_RESL;
  assign trg_edge = trg_s2_reg && !trg_s3_reg;
  assign chan_off = sc_reg[`ADCSC_CH_MSB:0] == `ADCSC_CH_OFF;
  assign done_ok = core_sts.done && state_reg == ADCSC_BUSY
    && (!cfg_reg[`ADCSC_BIT_CMP_EN] || core_sts.cmp_true);
  ////////////////////////////////////////////////////////////////////////////
  // Write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
    end else if (wr_go) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Ready flags and write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ADCSC_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_hold_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_hold_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        // Unmapped addresses answer with an error
        if (aw_addr_reg == `ADCSC_OFF_SC || aw_addr_reg == `ADCSC_OFF_CFG
            || aw_addr_reg == `ADCSC_OFF_IRQ_STAT || aw_addr_reg == `ADCSC_OFF_IRQ_MASK) begin
          s_axi_bresp <= `ADCSC_RESP_OKAY;
        end else begin
          s_axi_bresp <= `ADCSC_RESP_SLVERR;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Read channel, one beat per address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `ADCSC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `ADCSC_RESP_OKAY;
        unique case (s_axi_araddr)
          `ADCSC_OFF_SC: s_axi_rdata <= {24'h0, sc_reg};
          `ADCSC_OFF_CFG: s_axi_rdata <= {30'h0, cfg_reg};
          `ADCSC_OFF_RESL: s_axi_rdata <= {24'h0, resl_reg};
          `ADCSC_OFF_IRQ_STAT: s_axi_rdata <= {31'h0, irq_stat_reg};
          `ADCSC_OFF_IRQ_MASK: s_axi_rdata <= {31'h0, irq_mask_reg};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `ADCSC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Hardware trigger synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trg_s1_reg <= 1'b0;
      trg_s2_reg <= 1'b0;
      trg_s3_reg <= 1'b0;
    end else begin
      trg_s1_reg <= hw_conv_trigger;
      trg_s2_reg <= trg_s1_reg;
      trg_s3_reg <= trg_s2_reg;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Control bits; completion flag set wins over its clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sc_reg <= `ADCSC_SC_RESET;
      cfg_reg <= `ADCSC_CFG_RESET;
      irq_mask_reg <= 1'b0;
    end else begin
      if (wr_sc) begin
        sc_reg[6:0] <= w_data_reg[6:0];
      end
      if (wr_go && aw_addr_reg == `ADCSC_OFF_CFG && w_strb_reg[0]) begin
        cfg_reg <= w_data_reg[1:0];
      end
      if (wr_go && aw_addr_reg == `ADCSC_OFF_IRQ_MASK && w_strb_reg[0]) begin
        irq_mask_reg <= w_data_reg[0];
      end
      if (done_ok) begin
        sc_reg[`ADCSC_BIT_DONE] <= 1'b1;
      end else if (wr_sc || rd_resl) begin
        sc_reg[`ADCSC_BIT_DONE] <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Result capture and interrupt status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resl_reg <= 8'h00;
      irq_stat_reg <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (done_ok) begin
        resl_reg <= core_sts.result_low;
      end
      if (done_ok && sc_reg[`ADCSC_BIT_IRQ_EN]) begin
        irq_stat_reg <= 1'b1;
      end else if (wr_go && aw_addr_reg == `ADCSC_OFF_IRQ_STAT && w_data_reg[0]) begin
        irq_stat_reg <= 1'b0;
      end
      irq <= irq_stat_reg && irq_mask_reg;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ADCSC_IDLE;
      core_ctl <= '0;
    end else begin
      core_ctl.start <= 1'b0;
      core_ctl.abort <= 1'b0;
      // Powered only while converting; armed and idle both rest in low power
      core_ctl.powered <= !chan_off && state_reg == ADCSC_BUSY;
      if (wr_sc) begin
        core_ctl.abort <= state_reg == ADCSC_BUSY;
        if (w_data_reg[`ADCSC_CH_MSB:0] == `ADCSC_CH_OFF) begin
          state_reg <= ADCSC_IDLE;
        end else if (cfg_reg[`ADCSC_BIT_HWTRG]) begin
          state_reg <= ADCSC_ARMED;
        end else begin
          state_reg <= ADCSC_BUSY;
          core_ctl.start <= 1'b1;
          core_ctl.powered <= 1'b1;
        end
      end else begin
        unique case (state_reg)
          ADCSC_IDLE: ;
          ADCSC_ARMED: if (trg_edge && !chan_off) begin
            state_reg <= ADCSC_BUSY;
            core_ctl.start <= 1'b1;
            core_ctl.powered <= 1'b1;
          end
          ADCSC_BUSY: if (core_sts.done) begin
            if (sc_reg[`ADCSC_BIT_CONT] && !cfg_reg[`ADCSC_BIT_HWTRG]) begin
              core_ctl.start <= 1'b1;
            end else if (sc_reg[`ADCSC_BIT_CONT]) begin
              core_ctl.start <= 1'b1;
            end else begin
              state_reg <= cfg_reg[`ADCSC_BIT_HWTRG] ? ADCSC_ARMED : ADCSC_IDLE;
            end
          end
          default: state_reg <= ADCSC_IDLE;
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Multiplexer selection, registered
  adcsc_chan_decode u_decode (
    .input_channel_sel(sc_reg[`ADCSC_CH_MSB:0]),
    .mux_sel(mux_next)
  );
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mux_sel <= '0;
    end else begin
      mux_sel <= mux_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_flag_set;
    @(posedge aclk) disable iff (!aresetn)
    done_ok |=> sc_reg[`ADCSC_BIT_DONE];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("done flag not set");
  property p_cmp_gate;
    @(posedge aclk) disable iff (!aresetn)
    (cfg_reg[`ADCSC_BIT_CMP_EN] && core_sts.done && !core_sts.cmp_true && !sc_reg[7])
      |=> !sc_reg[`ADCSC_BIT_DONE];
  endproperty
  a_cmp_gate: assert property (p_cmp_gate) else $error("flag set on false compare");
  property p_clear;
    @(posedge aclk) disable iff (!aresetn)
    (rd_resl && !done_ok) |=> !sc_reg[`ADCSC_BIT_DONE];
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");
  property p_irq;
    @(posedge aclk) disable iff (!aresetn)
    (done_ok && sc_reg[6] && irq_mask_reg) |=> ##1 irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");
  property p_sw_start;
    @(posedge aclk) disable iff (!aresetn)
    (wr_sc && !cfg_reg[0] && w_data_reg[4:0] != 5'h1f) |=> core_ctl.start;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("no start on write");
  property p_off_nostart;
    @(posedge aclk) disable iff (!aresetn)
    (wr_sc && w_data_reg[4:0] == 5'h1f) |=> !core_ctl.start ##1 !core_ctl.powered;
  endproperty
  a_off_nostart: assert property (p_off_nostart) else $error("start on off code");
  property p_off_mux;
    @(posedge aclk) disable iff (!aresetn)
    chan_off |=> mux_sel == '0;
  endproperty
  a_off_mux: assert property (p_off_mux) else $error("input not isolated");
  property p_abort;
    @(posedge aclk) disable iff (!aresetn)
    (wr_sc && state_reg == ADCSC_BUSY) |=> core_ctl.abort;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort on write");
endmodule : adcsc_ctrl

// File: testbench/adcsc_core_model.sv
`timescale 1ns/1ps
// Behavioural converter core: one conversion per start pulse
module adcsc_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire adcsc_pkg::adcsc_core_ctl_t ctl,
  input wire logic cmp_val,
  input wire logic [5:0] conv_len,
  output adcsc_pkg::adcsc_core_sts_t sts
);
  import adcsc_pkg::*;
  logic [5:0] cnt_reg; // Cycles left in this conversion
  logic busy_reg; // Conversion under way
  ////////////////////////////////////////////////////////////////
  // Counts out a conversion; abort drops it, start restarts it
  always_ff @(posedge aclk) begin
    sts.done <= 1'b0;
    // Compare flag is only meaningful beside done
    sts.cmp_true <= ~cmp_val;
    if (!aresetn) begin
      busy_reg <= 1'b0;
      cnt_reg <= 6'h00;
      sts.result_low <= 8'h00;
    end else if (ctl.start) begin
      busy_reg <= 1'b1;
      cnt_reg <= conv_len;
    end else if (ctl.abort) begin
      busy_reg <= 1'b0;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg - 6'h01;
      // End of conversion: one-cycle done with result
      if (cnt_reg == 6'h00) begin
        busy_reg <= 1'b0;
        sts.done <= 1'b1;
        sts.cmp_true <= cmp_val;
        sts.result_low <= sts.result_low + 8'h01;
      end
    end
  end
endmodule : adcsc_core_model

// File: testbench/tb.sv
`timescale 1ns/1ps
`include "adcsc_params.svh"
module tb;
  import adcsc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic trg = 1'b0;
  logic cmpv = 1'b1;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [5:0] clen = 6'h04;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [1:0] wresp = 2'h0; // Write response of the last write
  logic [31:0] rdata;
  adcsc_core_ctl_t ctl;
  adcsc_core_sts_t sts;
  adcsc_mux_t mux;
  int n_mismatch = 0;
  int compares = 0;
  int n_st = 0;
  int n_ab = 0;
  // Channel table: code and expected selection
  logic [4:0] rc [8] = '{5'h00, 5'h0f, 5'h10, 5'h1b, 5'h1c, 5'h1d, 5'h1e, 5'h1f};
  logic [29:0] rm [8] = '{30'h4, 30'h20000, 30'h40000, 30'h20000000, 30'h0, 30'h2,
                         30'h1, 30'h0};
  ////////////////////////////////////////////////////////////////
  adcsc_ctrl uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .hw_conv_trigger(trg), .core_sts(sts),
    .core_ctl(ctl), .mux_sel(mux), .irq(irq));
  adcsc_core_model core (.aclk(aclk), .aresetn(aresetn), .ctl(ctl),
    .cmp_val(cmpv), .conv_len(clen), .sts(sts));
  ////////////////////////////////////////////////////////////////
  // Clock and start/abort counters
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    if (ctl.start === 1'b1) n_st <= n_st + 1;
    if (ctl.abort === 1'b1) n_ab <= n_ab + 1;
  end
  ////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ad, dd;
    int i;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (!ad && awready) begin
        awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (!dd && wready) begin
        wvalid <= 1'b0;
        dd = 1'b1;
      end
      if (bvalid) break;
    end
    wresp = bresp;
    bready <= 1'b0;
    if (i == 40) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (i == 40) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask : rd
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int s0;
    cyc(3);
    aresetn <= 1'b1;
    rd(`ADCSC_OFF_SC, d, r);
    chk("sc_reset", 32'h1f, d);
    chk("powered_reset", 32'h0, {31'h0, ctl.powered});
    rd(12'h014, d, r);
    chk("unmapped_resp", 32'h2, {30'h0, r});
    chk("unmapped_data", 32'h0, d);
    wr(12'h014, 32'h0);
    chk("wr_unmapped", 32'h2, {30'h0, wresp});
    // Table of channel codes, single software conversions
    for (int k = 0; k < 8; k++) begin
      s0 = n_st;
      wr(`ADCSC_OFF_SC, {27'h0, rc[k]});
      chk("wr_okay", 32'h0, {30'h0, wresp});
      cyc(20);
      chk("mux_sel", {2'h0, rm[k]}, {2'h0, mux});
      chk("starts", (rc[k] == 5'h1f) ? 0 : 1, n_st - s0);
      rd(`ADCSC_OFF_SC, d, r);
      chk("sc_done", {24'h0, rc[k] != 5'h1f, 2'h0, rc[k]}, d);
      chk("powered_idle", 32'h0, {31'h0, ctl.powered});
    end
    // Result read and control write both clear the flag
    wr(`ADCSC_OFF_SC, 32'h03);
    cyc(20);
    rd(`ADCSC_OFF_RESL, d, r);
    rd(`ADCSC_OFF_SC, d, r);
    chk("clr_by_read", 32'h03, d);
    wr(`ADCSC_OFF_SC, 32'h03);
    cyc(20);
    wr(`ADCSC_OFF_SC, 32'h1f);
    rd(`ADCSC_OFF_SC, d, r);
    chk("clr_by_write", 32'h1f, d);
    // Compare enabled: flag only when compare true
    wr(`ADCSC_OFF_CFG, 32'h2);
    cmpv <= 1'b0;
    wr(`ADCSC_OFF_SC, 32'h03);
    cyc(20);
    rd(`ADCSC_OFF_SC, d, r);
    chk("cmp_false", 32'h03, d);
    cmpv <= 1'b1;
    wr(`ADCSC_OFF_SC, 32'h03);
    cyc(20);
    rd(`ADCSC_OFF_SC, d, r);
    chk("cmp_true", 32'h83, d);
    wr(`ADCSC_OFF_CFG, 32'h0);
    // Interrupt raised, cleared, masked, disabled
    wr(`ADCSC_OFF_IRQ_MASK, 32'h1);
    wr(`ADCSC_OFF_SC, 32'h43);
    cyc(20);
    chk("irq_set", 32'h1, {31'h0, irq});
    wr(`ADCSC_OFF_IRQ_STAT, 32'h1);
    cyc(2);
    chk("irq_clr", 32'h0, {31'h0, irq});
    wr(`ADCSC_OFF_IRQ_MASK, 32'h0);
    wr(`ADCSC_OFF_SC, 32'h43);
    cyc(20);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rd(`ADCSC_OFF_IRQ_STAT, d, r);
    chk("stat_masked", 32'h1, d);
    wr(`ADCSC_OFF_IRQ_STAT, 32'h1);
    wr(`ADCSC_OFF_IRQ_MASK, 32'h1);
    wr(`ADCSC_OFF_SC, 32'h03);
    cyc(20);
    chk("irq_en_low", 32'h0, {31'h0, irq});
    // Continuous software run, stopped by the off code
    s0 = n_st;
    wr(`ADCSC_OFF_SC, 32'h23);
    cyc(40);
    chk("cont_runs", 32'h1, {31'h0, (n_st - s0) >= 3});
    wr(`ADCSC_OFF_SC, 32'h3f);
    cyc(2);
    s0 = n_st;
    cyc(20);
    chk("cont_stop", 0, n_st - s0);
    chk("mux_off", 32'h0, {2'h0, mux});
    // Hardware trigger: single then continuous
    wr(`ADCSC_OFF_CFG, 32'h1);
    s0 = n_st;
    wr(`ADCSC_OFF_SC, 32'h02);
    cyc(20);
    chk("hw_wait", 0, n_st - s0);
    trg <= 1'b1;
    cyc(20);
    chk("hw_single", 1, n_st - s0);
    chk("hw_idle_power", 32'h0, {31'h0, ctl.powered});
    trg <= 1'b0;
    wr(`ADCSC_OFF_SC, 32'h22);
    s0 = n_st;
    trg <= 1'b1;
    cyc(40);
    chk("hw_cont", 32'h1, {31'h0, (n_st - s0) >= 3});
    trg <= 1'b0;
    wr(`ADCSC_OFF_SC, 32'h3f);
    wr(`ADCSC_OFF_CFG, 32'h0);
    // Write during a slow conversion aborts and restarts
    clen <= 6'h30;
    wr(`ADCSC_OFF_SC, 32'h04);
    cyc(3);
    s0 = n_st;
    d = n_ab;
    wr(`ADCSC_OFF_SC, 32'h05);
    cyc(2);
    chk("abort", 1, n_ab - d);
    chk("restart", 1, n_st - s0);
    chk("mux_new", 32'h80, {2'h0, mux});
    cyc(60);
    report_and_stop();
  end
endmodule : tb
